// ### hw/ttj_regs.v
// register bank for bank trims, sample-lsb marker control and serial link control
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`include "ttj_defines.vh"

// How it works
// - zero-degree trim, 8-bit, used at zero phase
// - minus-90 trim, 8-bit, used at -90 phase
// - trims load factory value after reset
// - timestamp enable puts marker on sample lsb
// - timestamp beats calibration state on lsb
// - marker shares the sample pipeline latency
// - 8-bit mode: marker replaces 8-bit lsb
// - 12-bit mode: marker replaces 12-bit lsb
// - lane alignment control-bit count always zero
// - lsb control at 0x160, resets 0x00
// - link enable at 0x200, resets 0x01
// - link output mode at 0x201, resets 0x02
// - frames per multiframe at 0x202, resets 0x1F
// - manual sync request at 0x203, resets 0x01
// - link control 0x204 = 0x02, test 0x205 = 0x00
// - identifier 0x206, frame char 0x207, reset zero
// - status at 0x208, power-down 0x209 resets 0x00
module ttj_regs #(
   parameter ADDR_W = 12,
   parameter SAMPLE_LAT = 4
) (
   // clock and reset
   input wire clk_in,
   input wire rst_n_in,
   // axi4-lite write address
   input wire [ADDR_W-1:0] s_axi_awaddr_in,
   input wire s_axi_awvalid_in,
   output wire s_axi_awready_out,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata_in,
   input wire [3:0] s_axi_wstrb_in,
   input wire s_axi_wvalid_in,
   output wire s_axi_wready_out,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp_out,
   output reg s_axi_bvalid_out,
   input wire s_axi_bready_in,
   // axi4-lite read
   input wire [ADDR_W-1:0] s_axi_araddr_in,
   input wire s_axi_arvalid_in,
   output wire s_axi_arready_out,
   output reg [31:0] s_axi_rdata_out,
   output reg [1:0] s_axi_rresp_out,
   output reg s_axi_rvalid_out,
   input wire s_axi_rready_in,
   // factory trims {b5 m90, b5 zero, b4 m90, b4 zero}
   input wire [31:0] factory_trim_in,
   input wire clock_phase_m90_in,
   output reg [7:0] bank4_trim_out,
   output reg [7:0] bank5_trim_out,
   // sample path
   input wire [11:0] sample_in,
   input wire sample_valid_in,
   input wire timestamp_in,
   input wire cal_state_in,
   input wire cal_state_en_in,
   input wire sample_8bit_in,
   output reg [11:0] sample_out,
   output reg sample_valid_out,
   output reg [1:0] ila_cs_out,
   // link control
   input wire [7:0] link_system_status_in,
   output reg link_enable_out,
   output reg link_reset_out,
   output reg [4:0] link_output_mode_out,
   output reg [4:0] frames_per_multiframe_out,
   output reg manual_sync_request_n_out,
   output reg [7:0] link_control_out,
   output reg [7:0] test_pattern_control_out,
   output reg [7:0] device_identifier_param_out,
   output reg [7:0] frame_character_out,
   output reg [7:0] channel_power_down_out
);

   // ************************************************
   // reset release
   // ************************************************
   reg rst_meta_q;
   reg rst_sync_q;
   wire rst_n;

   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // assertion is immediate; release waits two edges so no flop leaves reset on a torn edge
   assign rst_n = rst_sync_q;

   // ************************************************
   // decode
   // ************************************************
   // misaligned or unmapped addresses give no slot and are answered with an error
   function [3:0] slot_of;
      input [ADDR_W-1:0] addr;
      reg [9:0] idx;
      begin
         idx = addr[11:2];
         slot_of = `TTJ_SLOT_NONE;
         if (addr[1:0] == 2'h0) begin
            case (idx)
               `TTJ_IDX_B4_TRIM_ZERO: slot_of = `TTJ_SLOT_B4Z;
               `TTJ_IDX_B4_TRIM_M90: slot_of = `TTJ_SLOT_B4M;
               `TTJ_IDX_B5_TRIM_ZERO: slot_of = `TTJ_SLOT_B5Z;
               `TTJ_IDX_B5_TRIM_M90: slot_of = `TTJ_SLOT_B5M;
               `TTJ_IDX_LSB_CTRL: slot_of = `TTJ_SLOT_LSB;
               `TTJ_IDX_STATUS: slot_of = `TTJ_SLOT_STATUS;
               `TTJ_IDX_PWR_DOWN: slot_of = `TTJ_SLOT_PD;
               default: begin
                  // 0x200..0x207 sit in consecutive slots
                  if (idx >= `TTJ_IDX_LINK_EN && idx <= `TTJ_IDX_FRAME_CHAR) begin
                     slot_of = `TTJ_SLOT_LINK0 + {1'b0, idx[2:0]};
                  end
               end
            endcase
         end
      end
   endfunction

   // trims fall to the default here and take the factory value one cycle later
   function [7:0] reset_of;
      input [3:0] slot;
      begin
         case (slot)
            `TTJ_SLOT_LSB: reset_of = `TTJ_RST_LSB_CTRL;
            4'h5: reset_of = `TTJ_RST_LINK_EN;
            4'h6: reset_of = `TTJ_RST_LINK_MODE;
            4'h7: reset_of = `TTJ_RST_FRAMES_PMF;
            4'h8: reset_of = `TTJ_RST_SYNC_REQ;
            4'h9: reset_of = `TTJ_RST_LINK_CTRL;
            4'hA: reset_of = `TTJ_RST_TEST_PAT;
            4'hB: reset_of = `TTJ_RST_DEV_ID;
            4'hC: reset_of = `TTJ_RST_FRAME_CHAR;
            `TTJ_SLOT_PD: reset_of = `TTJ_RST_PWR_DOWN;
            default: reset_of = `TTJ_RST_TRIM;
         endcase
      end
   endfunction

   // ************************************************
   // axi4-lite write side
   // ************************************************
   reg aw_held_q;
   reg w_held_q;
   reg [ADDR_W-1:0] awaddr_q;
   reg [7:0] wbyte_q;
   reg wlane_q;
   wire do_write;
   wire [3:0] wslot;

   // both readies drop while the answer stands, so one write at most is under way
   assign s_axi_awready_out = !aw_held_q && !s_axi_bvalid_out;
   assign s_axi_wready_out = !w_held_q && !s_axi_bvalid_out;
   // a write with byte lane 0 off is answered but changes nothing
   assign do_write = aw_held_q && w_held_q && !s_axi_bvalid_out;
   assign wslot = slot_of(awaddr_q);

   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= {ADDR_W{1'b0}};
         wbyte_q <= 8'h00;
         wlane_q <= 1'b0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= `TTJ_RESP_OKAY;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held_q <= 1'b1;
            wbyte_q <= s_axi_wdata_in[7:0];
            wlane_q <= s_axi_wstrb_in[0];
         end
         if (do_write) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= (wslot == `TTJ_SLOT_NONE) ? `TTJ_RESP_SLVERR : `TTJ_RESP_OKAY;
         end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
      end
   end

   // ************************************************
   // register storage
   // ************************************************
   // trims reset only to the constant 0x00: the factory value is caught on the
   // first cycle after release, since an async reset may load only constants
   reg [7:0] regs_q [0:`TTJ_NUM_SLOTS-1];
   reg trim_loaded_q;
   integer i;

   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         trim_loaded_q <= 1'b0;
         for (i = 0; i < `TTJ_NUM_SLOTS; i = i + 1) begin
            regs_q[i] <= reset_of(i[3:0]);
         end
      end else begin
         if (!trim_loaded_q) begin
            trim_loaded_q <= 1'b1;
            for (i = 0; i < 4; i = i + 1) begin
               regs_q[i] <= factory_trim_in[i*8 +: 8];
            end
         end else if (do_write && wlane_q && wslot < `TTJ_NUM_SLOTS) begin
            // status is read-only; its slot is above the storage range
            // reserved bits are stored as written; software keeps them zero
            regs_q[wslot] <= wbyte_q;
         end
      end
   end

   // ************************************************
   // axi4-lite read side
   // ************************************************
   wire [3:0] rslot;
   reg [7:0] rbyte;

   // the address is decoded as it is accepted; the data follow one cycle later
   assign s_axi_arready_out = !s_axi_rvalid_out;
   assign rslot = slot_of(s_axi_araddr_in);

   always @* begin
      rbyte = 8'h00;
      // status has no storage: it shows the live input
      if (rslot == `TTJ_SLOT_STATUS) begin
         rbyte = link_system_status_in;
      end else if (rslot < `TTJ_NUM_SLOTS) begin
         rbyte = regs_q[rslot];
      end
   end

   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h00000000;
         s_axi_rresp_out <= `TTJ_RESP_OKAY;
      end else if (s_axi_arvalid_in && s_axi_arready_out) begin
         s_axi_rvalid_out <= 1'b1;
         s_axi_rdata_out <= {24'h000000, rbyte};
         s_axi_rresp_out <= (rslot == `TTJ_SLOT_NONE) ? `TTJ_RESP_SLVERR : `TTJ_RESP_OKAY;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
         s_axi_rvalid_out <= 1'b0;
      end
   end

   // ************************************************
   // trim and link outputs
   // ************************************************
   // every output here lags its register by one cycle
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         bank4_trim_out <= `TTJ_RST_TRIM;
         bank5_trim_out <= `TTJ_RST_TRIM;
         link_enable_out <= 1'b0;
         link_reset_out <= 1'b1;
         link_output_mode_out <= 5'h00;
         frames_per_multiframe_out <= 5'h00;
         manual_sync_request_n_out <= 1'b1;
         link_control_out <= 8'h00;
         test_pattern_control_out <= 8'h00;
         device_identifier_param_out <= 8'h00;
         frame_character_out <= 8'h00;
         channel_power_down_out <= 8'h00;
      end else begin
         if (clock_phase_m90_in) begin
            bank4_trim_out <= regs_q[`TTJ_SLOT_B4M];
            bank5_trim_out <= regs_q[`TTJ_SLOT_B5M];
         end else begin
            bank4_trim_out <= regs_q[`TTJ_SLOT_B4Z];
            bank5_trim_out <= regs_q[`TTJ_SLOT_B5Z];
         end
         // with the enable clear the link stays in reset and its serializers down
         link_enable_out <= regs_q[5][`TTJ_BIT_LINK_EN];
         link_reset_out <= !regs_q[5][`TTJ_BIT_LINK_EN];
         link_output_mode_out <= regs_q[6][`TTJ_MODE_MSB:0];
         frames_per_multiframe_out <= regs_q[7][`TTJ_MODE_MSB:0];
         manual_sync_request_n_out <= regs_q[8][`TTJ_BIT_SYNC_N];
         link_control_out <= regs_q[9];
         test_pattern_control_out <= regs_q[10];
         device_identifier_param_out <= regs_q[11];
         frame_character_out <= regs_q[12];
         channel_power_down_out <= regs_q[`TTJ_SLOT_PD];
      end
   end

   // ************************************************
   // sample path with lsb marker
   // ************************************************
   // marker and calibration bit ride in the same stages as the sample,
   // so their alignment cannot drift whatever SAMPLE_LAT is
   reg [14:0] pipe_q [0:SAMPLE_LAT-1];

   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         pipe_q[0] <= 15'h0000;
      end else begin
         pipe_q[0] <= {sample_valid_in, cal_state_in, timestamp_in, sample_in};
      end
   end

   genvar g;
   generate
      for (g = 1; g < SAMPLE_LAT; g = g + 1) begin : stage
         always @(posedge clk_in or negedge rst_n) begin
            if (!rst_n) begin
               pipe_q[g] <= 15'h0000;
            end else begin
               pipe_q[g] <= pipe_q[g-1];
            end
         end
      end
   endgenerate

   wire [14:0] tail = pipe_q[SAMPLE_LAT-1];
   wire ts_en = regs_q[`TTJ_SLOT_LSB][`TTJ_BIT_TS_EN];
   reg mark_en;
   reg mark_bit;
   reg [11:0] shaped;

   // calibration state only fills the lsb while the timestamp is off
   always @* begin
      mark_en = 1'b0;
      mark_bit = 1'b0;
      if (ts_en) begin
         mark_en = 1'b1;
         mark_bit = tail[12];
      end else if (cal_state_en_in) begin
         mark_en = 1'b1;
         mark_bit = tail[13];
      end
      shaped = tail[11:0];
      if (sample_8bit_in) begin
         // 8-bit samples sit left-justified in [11:4]
         shaped[3:0] = 4'h0;
         if (mark_en) begin
            shaped[4] = mark_bit;
         end
      end else if (mark_en) begin
         shaped[0] = mark_bit;
      end
   end

   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         sample_out <= 12'h000;
         sample_valid_out <= 1'b0;
         ila_cs_out <= `TTJ_ILA_CS_VAL;
      end else begin
         sample_out <= shaped;
         sample_valid_out <= tail[14];
         // the marker bit is never advertised to the receiver
         ila_cs_out <= `TTJ_ILA_CS_VAL;
      end
   end

endmodule

// ### hw/ttj_defines.vh
// register map, reset values and bus codes for the trim and link register bank
`ifndef TTJ_DEFINES_VH
`define TTJ_DEFINES_VH
// register indices; byte address is four times the index
`define TTJ_IDX_B4_TRIM_ZERO 10'h142
`define TTJ_IDX_B4_TRIM_M90 10'h143
`define TTJ_IDX_B5_TRIM_ZERO 10'h152
`define TTJ_IDX_B5_TRIM_M90 10'h153
`define TTJ_IDX_LSB_CTRL 10'h160
`define TTJ_IDX_LINK_EN 10'h200
`define TTJ_IDX_LINK_MODE 10'h201
`define TTJ_IDX_FRAMES_PMF 10'h202
`define TTJ_IDX_SYNC_REQ 10'h203
`define TTJ_IDX_LINK_CTRL 10'h204
`define TTJ_IDX_TEST_PAT 10'h205
`define TTJ_IDX_DEV_ID 10'h206
`define TTJ_IDX_FRAME_CHAR 10'h207
`define TTJ_IDX_STATUS 10'h208
`define TTJ_IDX_PWR_DOWN 10'h209
// storage slots
`define TTJ_SLOT_B4Z 4'h0
`define TTJ_SLOT_B4M 4'h1
`define TTJ_SLOT_B5Z 4'h2
`define TTJ_SLOT_B5M 4'h3
`define TTJ_SLOT_LSB 4'h4
`define TTJ_SLOT_LINK0 4'h5
`define TTJ_SLOT_PD 4'hD
`define TTJ_SLOT_STATUS 4'hE
`define TTJ_SLOT_NONE 4'hF
`define TTJ_NUM_SLOTS 14
// reset values
`define TTJ_RST_LSB_CTRL 8'h00
`define TTJ_RST_LINK_EN 8'h01
`define TTJ_RST_LINK_MODE 8'h02
`define TTJ_RST_FRAMES_PMF 8'h1F
`define TTJ_RST_SYNC_REQ 8'h01
`define TTJ_RST_LINK_CTRL 8'h02
`define TTJ_RST_TEST_PAT 8'h00
`define TTJ_RST_DEV_ID 8'h00
`define TTJ_RST_FRAME_CHAR 8'h00
`define TTJ_RST_PWR_DOWN 8'h00
`define TTJ_RST_TRIM 8'h00
// field positions
`define TTJ_BIT_TS_EN 0
`define TTJ_BIT_LINK_EN 0
`define TTJ_BIT_SYNC_N 0
`define TTJ_MODE_MSB 4
`define TTJ_ILA_CS_VAL 2'h0
// bus responses
`define TTJ_RESP_OKAY 2'h0
`define TTJ_RESP_SLVERR 2'h2
`endif

// ### bench/ttj_regs_checker.sv
// assertions on the ports of the trim, marker and link register bank
`include "ttj_defines.vh"
module ttj_regs_checker #(
   parameter SAMPLE_LAT = 4
) (
   input wire clk_in,
   input wire rst_n_in,
   input wire s_axi_awvalid_in,
   input wire s_axi_awready_out,
   input wire s_axi_wvalid_in,
   input wire s_axi_wready_out,
   input wire s_axi_bvalid_out,
   input wire s_axi_bready_in,
   input wire s_axi_arvalid_in,
   input wire s_axi_arready_out,
   input wire [31:0] s_axi_rdata_out,
   input wire s_axi_rvalid_out,
   input wire s_axi_rready_in,
   input wire [11:0] sample_in,
   input wire sample_valid_in,
   input wire sample_8bit_in,
   input wire [11:0] sample_out,
   input wire sample_valid_out,
   input wire [1:0] ila_cs_out,
   input wire link_enable_out,
   input wire link_reset_out
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LAT = SAMPLE_LAT + 1;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // ****
   // register bus
   // ****
   a_read_lat: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("read answer late");
   a_write_resp: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
      && s_axi_wready_out |-> ##2 s_axi_bvalid_out)
      else $error("write answer late");
   a_resp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
      else $error("write answer dropped");
   a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
      |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
      else $error("read answer dropped");
   a_busy_refuse: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
      else $error("request taken while answering");
   a_link_hold: assert property (link_reset_out == !link_enable_out)
      else $error("link reset not inverse of enable");
   // ****
   // sample path
   // ****
   a_ila_zero: assert property (ila_cs_out == `TTJ_ILA_CS_VAL)
      else $error("alignment control count not zero");
   a_sample_lat: assert property (sample_valid_in |-> ##LAT sample_valid_out)
      else $error("sample latency wrong");
   a_wide_data: assert property (sample_valid_in ##LAT !sample_8bit_in
      |-> sample_out[11:1] == $past(sample_in[11:1], LAT))
      else $error("wide sample bits changed");
   a_narrow_data: assert property (sample_valid_in ##LAT sample_8bit_in
      |-> sample_out[11:5] == $past(sample_in[11:5], LAT) && sample_out[3:0] == 4'h0)
      else $error("narrow sample bits changed");
   c_write: cover property (s_axi_bvalid_out && s_axi_bready_in);
   c_read: cover property (s_axi_rvalid_out && s_axi_rready_in);
   c_marker: cover property (sample_valid_out && sample_out[0]);
endmodule

// ### bench/test_trim_timestamp_jesd_regs.sv
// self-checking bench for the trim, marker and link register bank
`include "ttj_defines.vh"
module test_trim_timestamp_jesd_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 0;
   logic rst_n_in = 0;
   logic [11:0] awaddr = 0, araddr = 0, sin = 0;
   logic awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0, sv = 0, ts = 0, cal = 0, cen = 0, m8 = 0;
   logic ph = 0;
   logic [3:0] strb = 4'hF;
   logic [31:0] wdata = 0;
   wire awr, wrdy, bv, arr, rv, svo, len, lrst, sync_n;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [11:0] sout;
   wire [7:0] b4t, b5t, lctl, pd, tpat, dev_id, frm_chr;
   wire [4:0] mode, kfr;
   int err_count = 0;
   int n_compared = 0;
   // cycles the bench waits before raising bready or rready
   int stall = 0;
   logic [9:0] ix_t [10] = '{`TTJ_IDX_LSB_CTRL, `TTJ_IDX_LINK_EN, `TTJ_IDX_LINK_MODE,
      `TTJ_IDX_FRAMES_PMF, `TTJ_IDX_SYNC_REQ, `TTJ_IDX_LINK_CTRL, `TTJ_IDX_TEST_PAT,
      `TTJ_IDX_DEV_ID, `TTJ_IDX_FRAME_CHAR, `TTJ_IDX_PWR_DOWN};
   logic [7:0] rv_t [10] = '{8'h00, 8'h01, 8'h02, 8'h1F, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [9:0] tr_t [4] = '{10'h142, 10'h143, 10'h152, 10'h153};
   logic [11:0] s_t [6] = '{12'h124, 12'h125, 12'hAB5, 12'hAA0, 12'h124, 12'h124};
   logic [11:0] e_t [6] = '{12'h125, 12'h124, 12'hAA0, 12'hAB0, 12'h125, 12'h124};
   logic [3:0] c_t [6] = '{4'h5, 4'h6, 4'h8, 4'h9, 4'h6, 4'h1};

   ttj_regs u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(strb), .s_axi_wvalid_in(wv),
      .s_axi_wready_out(wrdy), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
      .s_axi_bready_in(brdy), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
      .s_axi_arready_out(arr), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rv), .s_axi_rready_in(rrdy), .factory_trim_in(32'h44332211),
      .clock_phase_m90_in(ph), .bank4_trim_out(b4t), .bank5_trim_out(b5t),
      .sample_in(sin), .sample_valid_in(sv), .timestamp_in(ts), .cal_state_in(cal),
      .cal_state_en_in(cen), .sample_8bit_in(m8), .sample_out(sout),
      .sample_valid_out(svo), .ila_cs_out(), .link_system_status_in(8'hA5),
      .link_enable_out(len), .link_reset_out(lrst), .link_output_mode_out(mode),
      .frames_per_multiframe_out(kfr), .manual_sync_request_n_out(sync_n),
      .link_control_out(lctl), .test_pattern_control_out(tpat),
      .device_identifier_param_out(dev_id), .frame_character_out(frm_chr),
      .channel_power_down_out(pd));

   initial begin
      forever #5 clk_in = ~clk_in;
   end
   // ****
   // tasks
   // ****
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask
   // every bus wait is bounded so a dead slave cannot hang the run
   task automatic tick(inout int n);
      @(posedge clk_in);
      n++;
      if (n > 50) begin
         $display("CHECK FAILED bus_wait expected %0d seen %0d", 50, n);
         err_count++;
         end_sim;
      end
   endtask
   task automatic wr(input logic [9:0] ix, input logic [7:0] d, input logic [1:0] er);
      int n;
      logic done;
      n = 0;
      done = 0;
      @(posedge clk_in);
      awaddr <= {ix, 2'b00};
      wdata <= {24'h0, d};
      awv <= 1;
      wv <= 1;
      brdy <= (stall == 0);
      while (!done) begin
         tick(n);
         if (awr) awv <= 0;
         if (wrdy) wv <= 0;
         if (bv && brdy) begin
            done = 1;
            brdy <= 0;
            cmp("bresp", {30'h0, er}, {30'h0, bresp});
         end else if (n >= stall) begin
            // a late ready makes the slave hold its answer
            brdy <= 1;
         end
      end
   endtask
   task automatic rd(input logic [9:0] ix, input logic [7:0] d, input logic [1:0] er);
      int n;
      logic done;
      n = 0;
      done = 0;
      @(posedge clk_in);
      araddr <= {ix, 2'b00};
      arv <= 1;
      rrdy <= (stall == 0);
      while (!done) begin
         tick(n);
         if (arr) arv <= 0;
         if (rv && rrdy) begin
            done = 1;
            rrdy <= 0;
            cmp("rdata", {24'h0, d}, rdata);
            cmp("rresp", {30'h0, er}, {30'h0, rresp});
         end else if (n >= stall) begin
            rrdy <= 1;
         end
      end
   endtask
   task automatic smp(input logic [11:0] s, input logic [3:0] c, input logic [11:0] e);
      @(posedge clk_in);
      sin <= s;
      sv <= 1;
      {m8, cen, cal, ts} <= c;
      @(posedge clk_in);
      sv <= 0;
      ts <= 0;
      cal <= 0;
      repeat (4) @(posedge clk_in);
      #1;
      cmp("sample", {20'h0, e}, {20'h0, sout});
      cmp("sample_valid", 1, {31'h0, svo});
   endtask
   // ****
   // sequence
   // ****
   initial begin
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1;
      repeat (6) @(posedge clk_in);
      for (int i = 0; i < 10; i++) rd(ix_t[i], rv_t[i], `TTJ_RESP_OKAY);
      rd(`TTJ_IDX_STATUS, 8'hA5, `TTJ_RESP_OKAY);
      for (int i = 0; i < 4; i++) rd(tr_t[i], 8'h11 * (i + 1), `TTJ_RESP_OKAY);
      $display("test reset values done");
      // link enable is the second entry, after lsb control, so it is cleared before the other link registers change
      for (int i = 0; i < 10; i++) begin
         wr(ix_t[i], rv_t[i] ^ 8'h01, `TTJ_RESP_OKAY);
         rd(ix_t[i], rv_t[i] ^ 8'h01, `TTJ_RESP_OKAY);
      end
      cmp("link_enable", 0, {31'h0, len});
      cmp("link_reset", 1, {31'h0, lrst});
      cmp("mode", 5'h03, {27'h0, mode});
      cmp("frames", 5'h1E, {27'h0, kfr});
      cmp("sync_n", 0, {31'h0, sync_n});
      cmp("link_control", 8'h03, {24'h0, lctl});
      cmp("power_down", 8'h01, {24'h0, pd});
      cmp("test_pattern", 8'h01, {24'h0, tpat});
      cmp("device_id", 8'h01, {24'h0, dev_id});
      cmp("frame_char", 8'h01, {24'h0, frm_chr});
      $display("test link registers done");
      for (int i = 0; i < 4; i++) wr(tr_t[i], 8'hC0 + i, `TTJ_RESP_OKAY);
      for (int p = 0; p < 2; p++) begin
         ph <= p[0];
         repeat (2) @(posedge clk_in);
         cmp("bank4_trim", 8'hC0 + p, {24'h0, b4t});
         cmp("bank5_trim", 8'hC2 + p, {24'h0, b5t});
      end
      $display("test trims done");
      rd(10'h161, 8'h00, `TTJ_RESP_SLVERR);
      wr(10'h144, 8'h00, `TTJ_RESP_SLVERR);
      stall = 3;
      wr(`TTJ_IDX_STATUS, 8'h55, `TTJ_RESP_OKAY);
      rd(`TTJ_IDX_STATUS, 8'hA5, `TTJ_RESP_OKAY);
      stall = 0;
      strb <= 4'h0;
      wr(`TTJ_IDX_DEV_ID, 8'h00, `TTJ_RESP_OKAY);
      strb <= 4'hF;
      rd(`TTJ_IDX_DEV_ID, 8'h01, `TTJ_RESP_OKAY);
      $display("test unmapped done");
      for (int i = 0; i < 6; i++) begin
         if (i == 4) wr(`TTJ_IDX_LSB_CTRL, 8'h00, `TTJ_RESP_OKAY);
         smp(s_t[i], c_t[i], e_t[i]);
      end
      $display("test sample marker done");
      end_sim;
   end
endmodule

bind ttj_regs ttj_regs_checker #(.SAMPLE_LAT(SAMPLE_LAT)) u_chk (.clk_in(clk_in),
   .rst_n_in(rst_n_in), .s_axi_awvalid_in(s_axi_awvalid_in),
   .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
   .s_axi_wready_out(s_axi_wready_out), .s_axi_bvalid_out(s_axi_bvalid_out),
   .s_axi_bready_in(s_axi_bready_in), .s_axi_arvalid_in(s_axi_arvalid_in),
   .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
   .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
   .sample_in(sample_in), .sample_valid_in(sample_valid_in), .sample_8bit_in(sample_8bit_in),
   .sample_out(sample_out), .sample_valid_out(sample_valid_out), .ila_cs_out(ila_cs_out),
   .link_enable_out(link_enable_out), .link_reset_out(link_reset_out));
